// ---- pmls_pkg.sv ----
// Purpose: constants and types for the transceiver start-up and MII latency model
// Assumes: mclk at 20 MHz; all times converted to mclk cycles here
// Notes:   all times round up to whole mclk cycles
// What this block does
// - straps latched 167 ms after power-up
// - reduced-pin mode shortens the power-up wait to 84 ms
// - straps latched 3 us after a pin or soft reset
// - strap pins become outputs 50 ns later
// - 100M J group 6 bits after TX_EN edge
// - 100M T group 6 bits after TX_EN drop
// - 100M CRS 20 bits, data 24 bits latency
// - 100M CRS drops 24 bits after T group
// - clock switching never shortens a clock phase
// - 10M transmit sampled on falling TX_CLK
// - 10M line output 3.5 bits after sample
// - 10M end of packet high 250-300 ns
// - 10M CRS within 630 ns typical, 1000 max
// - 10M RX_DV 10 bits after first preamble
package pmls_pkg;
	localparam int CLK_NS          = 50;
	localparam int PWR_WAIT_MS     = 167;
	localparam int RMII_WAIT_MS    = 84;
	localparam int RST_WAIT_US     = 3;
	localparam int DRV_DLY_NS      = 50;
	localparam int PWR_WAIT_CYC    = (PWR_WAIT_MS * 1000000 + CLK_NS - 1) / CLK_NS;
	localparam int RMII_WAIT_CYC   = (RMII_WAIT_MS * 1000000 + CLK_NS - 1) / CLK_NS;
	localparam int RST_WAIT_CYC    = (RST_WAIT_US * 1000 + CLK_NS - 1) / CLK_NS;
	localparam int DRV_DLY_CYC     = (DRV_DLY_NS + CLK_NS - 1) / CLK_NS;
	localparam int BIT100_NS       = 10;
	localparam int BIT10_NS        = 100;
	localparam int TX100_LAT_BITS  = 6;
	localparam int TX10_LAT_NS     = 350;
	localparam int RX100_CRS_BITS  = 20;
	localparam int RX100_DAT_BITS  = 24;
	localparam int RX10_CRS_NS     = 630;
	localparam int RX10_DV_BITS    = 10;
	localparam int EOP_HIGH_NS     = 300;
	localparam int TXC10_HALF_NS   = 200;
	localparam int TX100_CYC       = (TX100_LAT_BITS * BIT100_NS + CLK_NS - 1) / CLK_NS;
	localparam int TX10_CYC        = (TX10_LAT_NS + CLK_NS - 1) / CLK_NS;
	localparam int RX100_CRS_CYC   = (RX100_CRS_BITS * BIT100_NS + CLK_NS - 1) / CLK_NS;
	localparam int RX100_DAT_CYC   = (RX100_DAT_BITS * BIT100_NS + CLK_NS - 1) / CLK_NS;
	localparam int RX10_CRS_CYC    = (RX10_CRS_NS + CLK_NS - 1) / CLK_NS;
	localparam int RX10_DV_CYC     = (RX10_DV_BITS * BIT10_NS + CLK_NS - 1) / CLK_NS;
	localparam int EOP_HIGH_CYC    = (EOP_HIGH_NS + CLK_NS - 1) / CLK_NS;
	localparam int TXC10_HALF_CYC  = (TXC10_HALF_NS + CLK_NS - 1) / CLK_NS;
	localparam int TXC100_HALF_CYC = 1;
	localparam int HIST_DEPTH      = 32;
	localparam int STRAP_SPEED_BIT = 0;
	localparam int STRAP_RMII_BIT  = 1;
	localparam logic [31:0] CNT_RESET = 32'h0000_0000;

	typedef struct packed {
		logic       act;
		logic [3:0] nib;
	} pmls_sym_type;

	typedef enum logic [2:0] {
		PMLS_WAIT   = 3'b001,
		PMLS_SETTLE = 3'b010,
		PMLS_RUN    = 3'b100
	} pmls_state_type;
endpackage

// ---- pmls_core.sv ----
// Purpose: start-up sequencing, MII clocks and line latency model of the transceiver
// Assumes: all pin inputs asynchronous to mclk; soft_rst is an mclk pulse
// Notes:   100M clocks are a scaled model, since mclk cannot make 25 MHz
`timescale 1ns/100ps
module pmls_core
	import pmls_pkg::*;
#(
	parameter int STRAP_W  = 4,
	parameter int PWR_CYC  = PWR_WAIT_CYC,
	parameter int RMII_CYC = RMII_WAIT_CYC
) (
	input  wire logic               mclk,
	input  wire logic               rst_n,
	input  wire logic               hw_rst_n,
	input  wire logic               soft_rst,
	input  wire logic [STRAP_W-1:0] strap_i,
	output logic      [STRAP_W-1:0] strap_o,
	output logic      [STRAP_W-1:0] strap_oe,
	input  wire logic [STRAP_W-1:0] strap_drv,
	output logic                    mgmt_ready,
	output logic                    speed_100,
	output logic                    tx_clk,
	output logic                    rx_clk,
	input  wire pmls_sym_type       mac_tx,
	output pmls_sym_type            line_tx,
	output logic                    line_eop_high,
	input  wire pmls_sym_type       line_rx,
	output logic                    crs,
	output logic                    rx_dv,
	output logic      [3:0]         rxd
);
	localparam int A_TX100 = TX100_CYC;
	localparam int A_TX10  = TX10_CYC;
	localparam int A_DV10  = RX10_DV_CYC + 1;
	localparam int A_DAT   = RX100_DAT_CYC + 1;

	// synchronisers: first stage read only by the second
	logic [STRAP_W-1:0] strap_m_q, strap_s_q;
	logic               hrst_m_q, hrst_s_q;
	pmls_sym_type       tx_m_q, tx_s_q, rx_m_q, rx_s_q;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			strap_m_q <= '0;
			strap_s_q <= '0;
			// pin idles high; a low reset value would look like a pin reset after power-up
			hrst_m_q  <= 1'b1;
			hrst_s_q  <= 1'b1;
			tx_m_q    <= '0;
			tx_s_q    <= '0;
			rx_m_q    <= '0;
			rx_s_q    <= '0;
		end else begin
			strap_m_q <= strap_i;
			strap_s_q <= strap_m_q;
			hrst_m_q  <= hw_rst_n;
			hrst_s_q  <= hrst_m_q;
			tx_m_q    <= mac_tx;
			tx_s_q    <= tx_m_q;
			rx_m_q    <= line_rx;
			rx_s_q    <= rx_m_q;
		end
	end

	// start-up sequencing
	pmls_state_type     state_q, state_d;
	logic [31:0]        cnt_q, cnt_d;
	logic               by_rst_q, by_rst_d;
	logic [STRAP_W-1:0] strap_q, strap_d;
	logic [31:0]        target;

	always_comb begin
		if (by_rst_q)
			target = 32'(RST_WAIT_CYC);
		else if (strap_s_q[STRAP_RMII_BIT])
			target = 32'(RMII_CYC);
		else
			target = 32'(PWR_CYC);
		state_d  = state_q;
		cnt_d    = cnt_q;
		by_rst_d = by_rst_q;
		strap_d  = strap_q;
		if (!hrst_s_q || soft_rst) begin
			// pin reset holds the count at zero; the wait starts at release
			state_d  = PMLS_WAIT;
			cnt_d    = CNT_RESET;
			by_rst_d = 1'b1;
		end else begin
			unique case (state_q)
				PMLS_WAIT: begin
					cnt_d = cnt_q + 32'h0000_0001;
					if (cnt_d >= target) begin
						strap_d = strap_s_q;
						state_d = PMLS_SETTLE;
					end
				end
				PMLS_SETTLE: state_d = PMLS_RUN;
				PMLS_RUN:    state_d = PMLS_RUN;
			endcase
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			state_q  <= PMLS_WAIT;
			cnt_q    <= CNT_RESET;
			by_rst_q <= 1'b0;
			strap_q  <= '0;
		end else begin
			state_q  <= state_d;
			cnt_q    <= cnt_d;
			by_rst_q <= by_rst_d;
			strap_q  <= strap_d;
		end
	end

	assign mgmt_ready = (state_q == PMLS_RUN);
	assign strap_oe   = {STRAP_W{state_q == PMLS_RUN}};
	assign strap_o    = strap_drv;
	assign speed_100  = strap_q[STRAP_SPEED_BIT];

	// mii clock divider; half period reloads only at a toggle so no phase is cut short
	logic       clk_q, clk_d;
	logic [3:0] half_q, half_d, ph_q, ph_d;
	logic       tog, rise, fall;

	always_comb begin
		tog    = (ph_q == half_q - 4'h1);
		rise   = tog && !clk_q;
		fall   = tog && clk_q;
		clk_d  = tog ? !clk_q : clk_q;
		ph_d   = tog ? 4'h0 : ph_q + 4'h1;
		half_d = half_q;
		if (tog)
			half_d = speed_100 ? 4'(TXC100_HALF_CYC) : 4'(TXC10_HALF_CYC);
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			clk_q  <= 1'b0;
			half_q <= 4'(TXC10_HALF_CYC);
			ph_q   <= 4'h0;
		end else begin
			clk_q  <= clk_d;
			half_q <= half_d;
			ph_q   <= ph_d;
		end
	end

	assign tx_clk = clk_q;
	assign rx_clk = clk_q;

	// transmit path
	pmls_sym_type tx_smp_q, tx_smp_d;
	pmls_sym_type tx_h_q [HIST_DEPTH];
	pmls_sym_type tx_h_d [HIST_DEPTH];
	pmls_sym_type line_tx_q, line_tx_d;
	logic [3:0]   eop_q, eop_d;

	always_comb begin
		tx_smp_d = tx_smp_q;
		if (speed_100 ? rise : fall)
			tx_smp_d = tx_s_q;
		tx_h_d[0] = tx_smp_q;
		for (int i = 1; i < HIST_DEPTH; i++)
			tx_h_d[i] = tx_h_q[i-1];
		// tap picks the 100M J/T group or 10M line output delay from the sampling edge
		line_tx_d = speed_100 ? tx_h_q[TX100_CYC-2] : tx_h_q[TX10_CYC-2];
		eop_d = (eop_q != 4'h0) ? eop_q - 4'h1 : 4'h0;
		if (!speed_100 && line_tx_q.act && !line_tx_d.act)
			eop_d = 4'(EOP_HIGH_CYC);
	end

	// receive path
	pmls_sym_type rx_h_q [HIST_DEPTH];
	pmls_sym_type rx_h_d [HIST_DEPTH];
	logic         crs_q, crs_d, dv_q, dv_d;
	logic [3:0]   rxd_q, rxd_d;

	always_comb begin
		rx_h_d[0] = rx_s_q;
		for (int i = 1; i < HIST_DEPTH; i++)
			rx_h_d[i] = rx_h_q[i-1];
		if (speed_100) begin
			crs_d = rx_h_q[RX100_CRS_CYC-1].act || (crs_q && rx_h_q[RX100_DAT_CYC-1].act);
			dv_d  = rx_h_q[RX100_DAT_CYC-1].act;
			rxd_d = rx_h_q[RX100_DAT_CYC-1].nib;
		end else begin
			// crs follows the dv tap at packet end, as no separate off delay applies
			crs_d = rx_h_q[RX10_CRS_CYC-1].act || (crs_q && rx_h_q[RX10_DV_CYC-1].act);
			dv_d  = rx_h_q[RX10_DV_CYC-1].act;
			rxd_d = rx_h_q[RX10_DV_CYC-1].nib;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			tx_smp_q  <= '0;
			line_tx_q <= '0;
			eop_q     <= 4'h0;
			crs_q     <= 1'b0;
			dv_q      <= 1'b0;
			rxd_q     <= 4'h0;
			for (int i = 0; i < HIST_DEPTH; i++) begin
				tx_h_q[i] <= '0;
				rx_h_q[i] <= '0;
			end
		end else begin
			tx_smp_q  <= tx_smp_d;
			line_tx_q <= line_tx_d;
			eop_q     <= eop_d;
			crs_q     <= crs_d;
			dv_q      <= dv_d;
			rxd_q     <= rxd_d;
			for (int i = 0; i < HIST_DEPTH; i++) begin
				tx_h_q[i] <= tx_h_d[i];
				rx_h_q[i] <= rx_h_d[i];
			end
		end
	end

	assign line_tx       = line_tx_q;
	assign line_eop_high = (eop_q != 4'h0);
	assign crs           = crs_q;
	assign rx_dv         = dv_q;
	assign rxd           = rxd_q;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	drive_after_latch_a: assert property (state_q == PMLS_SETTLE && hrst_s_q && !soft_rst
		|=> strap_oe == '1 && mgmt_ready)
		else $error("strap pins not driven after latch");
	no_early_drive_a: assert property (state_q != PMLS_RUN |-> strap_oe == '0)
		else $error("strap pins driven before latch");
	rst_latch_a: assert property (by_rst_q && hrst_s_q && !soft_rst && state_q == PMLS_WAIT
		&& cnt_q == 32'(RST_WAIT_CYC - 1) |=> state_q == PMLS_SETTLE)
		else $error("reset latch-in time wrong");
	pwr_latch_a: assert property ($rose(state_q == PMLS_SETTLE) && !by_rst_q && !strap_s_q[STRAP_RMII_BIT]
		|-> $past(cnt_q) == 32'(PWR_CYC - 1))
		else $error("power-up latch-in time wrong");
	rmii_latch_a: assert property ($rose(state_q == PMLS_SETTLE) && !by_rst_q && strap_s_q[STRAP_RMII_BIT]
		|-> $past(cnt_q) == 32'(RMII_CYC - 1))
		else $error("reduced-pin latch-in time wrong");
	tx100_lat_a: assert property (speed_100 && $rose(tx_smp_q.act) |-> ##A_TX100 line_tx_q.act)
		else $error("100M transmit latency wrong");
	tx10_lat_a: assert property (!speed_100 && $rose(tx_smp_q.act) |->
		##A_TX10 (line_tx_q.act && !$past(line_tx_q.act)))
		else $error("10M transmit latency wrong");
	eop_hold_a: assert property (!speed_100 && $fell(line_tx_q.act) |-> line_eop_high[*5])
		else $error("end of packet high too short");
	dv10_lat_a: assert property (!speed_100 && $rose(rx_s_q.act) |->
		##A_DV10 (rx_dv && !$past(rx_dv)))
		else $error("10M rx_dv latency wrong");
	crs100_a: assert property (speed_100 && $rose(rx_s_q.act) |-> ##A_DAT (crs && rx_dv))
		else $error("100M carrier or data late");
	clk_phase_a: assert property ($changed(clk_q) && half_q == 4'(TXC10_HALF_CYC) |=> $stable(clk_q)[*3])
		else $error("10M clock phase shortened");

	ready_c: cover property ($rose(mgmt_ready));
	tx_frame_c: cover property ($rose(line_tx_q.act) ##[1:200] $fell(line_tx_q.act));
	rx_frame_c: cover property ($rose(rx_dv) ##[1:200] $fell(crs));
	soft_rst_c: cover property (mgmt_ready ##1 soft_rst);
endmodule

// ---- pmls_mac.sv ----
// Purpose: MAC and management station model facing pmls_core
// Assumes: tx_clk seen through mclk, one nibble per tx_clk
// Notes:   idle data lines toggle so a stale nibble never looks valid
`timescale 1ns/100ps
module pmls_mac
	import pmls_pkg::*;
(
	input  wire logic         mclk,
	input  wire logic         rst_n,
	input  wire logic         tx_clk,
	input  wire logic         mgmt_ready,
	input  wire logic         go,
	input  wire logic [3:0]   nib_in,
	output pmls_sym_type      mac_tx,
	output logic              pre_done
);
	logic       clk_q;
	logic [5:0] pre_q;
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			clk_q  <= 1'b0;
			mac_tx <= '0;
			pre_q  <= 6'h00;
		end else begin
			clk_q <= tx_clk;
			// change only just after a tx_clk rise
			if (tx_clk && !clk_q) begin
				mac_tx <= go ? pmls_sym_type'{1'b1, nib_in} : pmls_sym_type'{1'b0, ~mac_tx.nib};
			end
			// preamble of ones starts only once access is allowed
			if (!mgmt_ready) begin
				pre_q <= 6'h00;
			end else if (pre_q != 6'h20) begin
				pre_q <= pre_q + 6'h01;
			end
		end
	end
	assign pre_done = (pre_q == 6'h20);
endmodule

// ---- pmls_core_tb.sv ----
// Purpose: self-checking bench for pmls_core start-up, clocks and latencies
// Assumes: pmls_mac drives the MAC side; the line side is driven here
// Notes:   start-up waits shortened to 200 and 100 cycles
`timescale 1ns/100ps
module pmls_core_tb
	import pmls_pkg::*;
;
	localparam int PW = 200;
	localparam int RM = 100;
	logic         mclk = 0, rst_n = 0, hw_rst_n = 1, soft_rst = 0, go = 0;
	logic [3:0]   strap_i = 4'h1, strap_drv = 4'ha, strap_o, strap_oe, rxd;
	logic         mgmt_ready, speed_100, tx_clk, rx_clk, line_eop_high, crs, rx_dv, pre_done, la, ma;
	pmls_sym_type mac_tx, line_tx, line_rx = '0;
	int           n_mismatch = 0, total_checks = 0, cyc = 0, n, k;
	assign la = line_tx.act;
	assign ma = mac_tx.act;
	pmls_core #(.PWR_CYC(PW), .RMII_CYC(RM)) dut (.mclk, .rst_n, .hw_rst_n, .soft_rst, .strap_i, .strap_o,
		.strap_oe, .strap_drv, .mgmt_ready, .speed_100, .tx_clk, .rx_clk, .mac_tx, .line_tx, .line_eop_high,
		.line_rx, .crs, .rx_dv, .rxd);
	pmls_mac mac (.mclk, .rst_n, .tx_clk, .mgmt_ready, .go, .nib_in(4'h9), .mac_tx, .pre_done);
	// reference clock runs from time zero, through every reset
	always #25 mclk = ~mclk;
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 20000) begin
			n_mismatch++;
			stop_test;
		end
	end
	task automatic wt(ref logic s, input logic v, output int c);
		c = 0;
		while (s !== v && c < 4000) begin
			@(posedge mclk);
			c++;
		end
	endtask
	task rng(input string s, input int lo, input int hi, input int c);
		total_checks++;
		if (c < lo || c > hi) begin
			n_mismatch++;
			$display("MISMATCH %s expected %0d..%0d seen %0d", s, lo, hi, c);
		end
	endtask
	task eq(input string s, input logic [3:0] e, input logic [3:0] g);
		total_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", s, e, g);
		end
	endtask
	task t_pwr(input logic [3:0] st, input int tgt);
		strap_i <= st;
		rst_n   <= 1'b0;
		repeat (4) @(posedge mclk);
		rst_n <= 1'b1;
		@(posedge mclk);
		eq("oe in wait", 4'h0, strap_oe);
		wt(mgmt_ready, 1'b1, n);
		rng("ready wait", tgt, tgt + 5, n);
		eq("strap oe", 4'hf, strap_oe);
		eq("strap out", strap_drv, strap_o);
		eq("speed", {3'h0, st[0]}, {3'h0, speed_100});
		wt(pre_done, 1'b1, n);
		rng("preamble", 32, 32, n);
		$display("power-up test done");
	endtask
	task t_rst(input logic sw);
		strap_i <= 4'h2;
		if (sw) begin
			soft_rst <= 1'b1;
			@(posedge mclk);
			soft_rst <= 1'b0;
		end else begin
			hw_rst_n <= 1'b0;
			repeat (20) @(posedge mclk);
			hw_rst_n <= 1'b1;
		end
		@(posedge mclk);
		wt(mgmt_ready, 1'b1, n);
		rng("reset wait", RST_WAIT_CYC - 1, RST_WAIT_CYC + 5, n);
		eq("speed", 4'h0, {3'h0, speed_100});
		$display("reset test done");
	endtask
	task t_clk(input int h);
		// start from a low phase so the whole high phase is counted
		wt(tx_clk, 1'b0, n);
		wt(tx_clk, 1'b1, n);
		wt(tx_clk, 1'b0, n);
		rng("tx clk high", h, h, n);
		wt(rx_clk, 1'b0, n);
		wt(rx_clk, 1'b1, n);
		wt(rx_clk, 1'b0, n);
		rng("rx clk high", h, h, n);
		$display("clock test done");
	endtask
	task t_tx(input int lo, input int hi, input logic e10);
		go <= 1'b1;
		wt(ma, 1'b1, n);
		wt(la, 1'b1, n);
		rng("tx start", lo, hi, n);
		eq("tx nibble", 4'h9, line_tx.nib);
		repeat (8) @(posedge mclk);
		go <= 1'b0;
		wt(ma, 1'b0, n);
		wt(la, 1'b0, n);
		rng("tx end", lo, hi, n);
		if (e10) begin
			wt(line_eop_high, 1'b1, n);
			wt(line_eop_high, 1'b0, n);
			rng("eop high", 5, 7, n);
		end
		$display("transmit test done");
	endtask
	task t_rx(input int clo, input int chi, input int dlo, input int dhi);
		line_rx <= '{1'b1, 4'h5};
		@(posedge mclk);
		wt(crs, 1'b1, k);
		rng("crs on", clo, chi, k);
		wt(rx_dv, 1'b1, n);
		rng("rx dv", dlo, dhi, k + n);
		eq("rxd", 4'h5, rxd);
		line_rx <= '{1'b0, 4'ha};
		@(posedge mclk);
		wt(crs, 1'b0, n);
		rng("crs off", dlo, dhi, n);
		$display("receive test done");
	endtask
	task stop_test;
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	initial begin
		t_pwr(4'h1, PW);
		t_clk(TXC100_HALF_CYC);
		t_tx(TX100_CYC, TX100_CYC + 6, 1'b0);
		t_rx(RX100_CRS_CYC, RX100_CRS_CYC + 4, RX100_DAT_CYC, RX100_DAT_CYC + 4);
		t_rst(1'b0);
		t_pwr(4'h2, RM);
		t_clk(TXC10_HALF_CYC);
		t_tx(TX10_CYC, TXC10_HALF_CYC + TX10_CYC + 5, 1'b1);
		t_rx(RX10_CRS_CYC, 20, RX10_DV_CYC, RX10_DV_CYC + 4);
		t_rst(1'b1);
		stop_test;
	end
endmodule
